//--- design/mcs_pkg.sv
// constants shared by both ends of the motion controller serial port
// assumes a 20 MHz system clock on each end
package mcs_pkg;
  // frame layout
  localparam int FRAME_BITS = 40;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 32;
  localparam int WR_BIT = 39;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] FRAME_CNT = 6'h28;
  // status byte field positions
  localparam int ST_STOP_L = 5;
  localparam int ST_VEL = 3;
  localparam int ST_ERR = 1;
  localparam int ST_RST = 0;
  localparam logic [7:0] STATUS_RST = 8'h01;
  localparam logic [2:0] GFLAGS_RST = 3'h1;
  // device input bit positions in the filter vector
  localparam int IN_SCK = 0;
  localparam int IN_SEL = 1;
  localparam int IN_MOSI = 2;
  localparam int IN_DIS = 3;
  // idle pin levels: clock and select high, data low, disable high
  localparam logic [3:0] IN_IDLE = 4'hb;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int FILT_NS = 20;
  localparam int FILT_CYC_RAW = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_CYC = (FILT_CYC_RAW < 1) ? 1 : FILT_CYC_RAW;
  localparam int HALF_DIV_DEF = 4;
  // host register map (byte addresses, used unshifted as the bus address)
  localparam logic [3:0] CMD_OFS = 4'h0;
  localparam logic [3:0] WDATA_OFS = 4'h4;
  localparam logic [3:0] RDATA_OFS = 4'h8;
  localparam logic [3:0] STAT_OFS = 4'hc;
  localparam int STAT_BUSY = 0;
  localparam int STAT_BYTE_LSB = 8;
endpackage

//--- design/mcs_link_if.sv
// serial link between the controller host and the motion device port
// the bench connects both ends through one instance of this interface
`timescale 1ns/1ps
interface mcs_link_if;
  logic sck;
  logic select_low_line_n;
  logic mosi;
  logic miso;
  modport dev (
    input sck,
    input select_low_line_n,
    input mosi,
    output miso
  );
  modport host (
    output sck,
    output select_low_line_n,
    output mosi,
    input miso
  );
endinterface

//--- design/mcs_dev_end.sv
// device end of the motion controller serial port
// assumes register file on CLK answering REG_RDATA combinationally
// from REG_ADDR, and status inputs generated on the same CLK
// Behaviour
// - frame is address byte plus 32 data
// - master keeps select low whole frame
// - bit 39 high means write access
// - read data returned in next frame
// - after write, next frame echoes write data
// - read leaves register untouched, data ignored
// - every register moves as 32 bits
// - status byte replaces returned address byte
// - status captured at end of access
// - fixed status byte bit layout
// - error and reset flags clear on read
// - register data right aligned in word
// - sample on sck rise, drive after fall
// - bus clock idles high, mode 3
// - master gives at least 40 clocks
// - extra bits appear 40 clocks later
// - select rise latches last 40 bits
// - bus clock at most half system clock; the filter here allows only a quarter
// - inputs ignore pulses under 20 ns
`timescale 1ns/1ps
module mcs_dev_end
  import mcs_pkg::*;
#(
  parameter logic [ADDR_W-1:0] GFLAGS_ADDR = 7'h01
) (
  // system
  input wire logic CLK,
  input wire logic RST,
  // serial link
  mcs_link_if.dev LINK,
  // register file access
  output logic REG_WR,
  output logic REG_RD,
  output logic [ADDR_W-1:0] REG_ADDR,
  output logic [DATA_W-1:0] REG_WDATA,
  input wire logic [DATA_W-1:0] REG_RDATA,
  // status sources
  input wire logic [1:0] STOP_LEFT,
  input wire logic [1:0] VEL_REACHED,
  input wire logic [1:0] DRV_ERR_EVT,
  input wire logic RESET_EVT,
  output logic [2:0] GLOBAL_FLAGS,
  // driver disable
  input wire logic DRIVER_DISABLE_IN,
  output logic DRIVER_DISABLE
);

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_SHIFT = 3'b010,
    S_ISSUE = 3'b100
  } mcs_state_e;

  mcs_state_e state_r;
  logic [3:0] sy1_r, sy2_r;
  logic [FILT_CYC:0][3:0] hist_r;
  logic [3:0] filt_r, filt_nxt;
  logic [1:0] prev_r;
  logic sck_rise, sck_fall, sel_fall, sel_rise;
  logic [FRAME_BITS-1:0] shreg_r;
  logic [CNT_W-1:0] cnt_r;
  logic miso_r;
  logic [DATA_W-1:0] reply_r;
  logic [7:0] status_r, status_nxt;
  logic [2:0] glob_r;
  logic gclear;
  logic reg_wr_r, reg_rd_r;
  logic [ADDR_W-1:0] reg_addr_r;
  logic [DATA_W-1:0] reg_wdata_r;

  // two-flop synchronisers
  // only sy2_r reads sy1_r; nothing else may look at it
  always_ff @(posedge CLK) begin
    if (RST) begin
      sy1_r <= IN_IDLE;
      sy2_r <= IN_IDLE;
    end else begin
      sy1_r <= {DRIVER_DISABLE_IN, LINK.mosi, LINK.select_low_line_n,
                LINK.sck};
      sy2_r <= sy1_r;
    end
  end

  // sample history for the glitch filter
  always_ff @(posedge CLK) begin
    if (RST) begin
      hist_r <= {(FILT_CYC+1){IN_IDLE}};
    end else begin
      hist_r <= {hist_r[FILT_CYC-1:0], sy2_r};
    end
  end

  // glitch filter
  // a level is taken only once seen on FILT_CYC+1 samples; this
  // rejects far more than 20 ns, which costs latency and limits sck to a quarter of CLK
  always_comb begin
    filt_nxt = filt_r;
    for (int b = 0; b < 4; b++) begin
      logic all1, all0;
      all1 = 1'b1;
      all0 = 1'b1;
      for (int k = 0; k <= FILT_CYC; k++) begin
        all1 = all1 & hist_r[k][b];
        all0 = all0 & ~hist_r[k][b];
      end
      if (all1) begin
        filt_nxt[b] = 1'b1;
      end else if (all0) begin
        filt_nxt[b] = 1'b0;
      end
    end
  end

  // filtered levels; clock history resets to idle high
  always_ff @(posedge CLK) begin
    if (RST) begin
      filt_r <= IN_IDLE;
      prev_r <= 2'h3;
    end else begin
      filt_r <= filt_nxt;
      prev_r <= filt_r[IN_SEL:IN_SCK];
    end
  end

  // edge detection on filtered clock and select
  assign sck_rise = filt_r[IN_SCK] & ~prev_r[IN_SCK];
  assign sck_fall = ~filt_r[IN_SCK] & prev_r[IN_SCK];
  assign sel_fall = ~filt_r[IN_SEL] & prev_r[IN_SEL];
  assign sel_rise = filt_r[IN_SEL] & ~prev_r[IN_SEL];

  // frame state
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_r <= S_IDLE;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (sel_fall) begin
            state_r <= S_SHIFT;
          end
        end
        S_SHIFT: begin
          if (sel_rise) begin
            state_r <= (cnt_r == FRAME_CNT) ? S_ISSUE : S_IDLE;
          end
        end
        S_ISSUE: begin
          state_r <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // shift register and bit count
  always_ff @(posedge CLK) begin
    if (RST) begin
      shreg_r <= '0;
      cnt_r <= '0;
    end else if (state_r == S_IDLE && sel_fall) begin
      shreg_r <= {status_r, reply_r};
      cnt_r <= '0;
    end else if (state_r == S_SHIFT && sck_rise) begin
      shreg_r <= {shreg_r[FRAME_BITS-2:0], filt_r[IN_MOSI]};
      // count saturates at a full frame
      if (cnt_r != FRAME_CNT) begin
        cnt_r <= cnt_r + 6'h01;
      end
    end
  end

  // serial output
  always_ff @(posedge CLK) begin
    if (RST) begin
      miso_r <= 1'b0;
    end else if (state_r == S_IDLE && sel_fall) begin
      miso_r <= status_r[7];
    end else if (state_r == S_SHIFT && sck_fall) begin
      // bit 39 is the one received 40 clocks ago
      miso_r <= shreg_r[FRAME_BITS-1];
    end
  end

  assign LINK.miso = miso_r;

  // command to the register file, one-cycle strobes
  always_ff @(posedge CLK) begin
    if (RST) begin
      reg_wr_r <= 1'b0;
      reg_rd_r <= 1'b0;
      reg_addr_r <= '0;
      reg_wdata_r <= '0;
    end else if (state_r == S_SHIFT && sel_rise && cnt_r == FRAME_CNT) begin
      // bit 39 picks write or read
      reg_wr_r <= shreg_r[WR_BIT];
      // a read never strobes a write
      reg_rd_r <= ~shreg_r[WR_BIT];
      reg_addr_r <= shreg_r[WR_BIT-1:DATA_W];
      // low 32 bits are the data word
      reg_wdata_r <= shreg_r[DATA_W-1:0];
    end else begin
      reg_wr_r <= 1'b0;
      reg_rd_r <= 1'b0;
    end
  end

  // reply word for the next frame
  // read data is snapshotted here so a changing register stays whole
  always_ff @(posedge CLK) begin
    if (RST) begin
      reply_r <= '0;
    end else if (state_r == S_ISSUE) begin
      // a read returns the addressed word
      // full 32 bits, right aligned as given
      reply_r <= reg_wr_r ? reg_wdata_r : REG_RDATA;
    end
  end

  // read of the global flags register clears them
  assign gclear = (state_r == S_ISSUE) && reg_rd_r &&
                  (reg_addr_r == GFLAGS_ADDR);

  // sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      glob_r <= GFLAGS_RST;
    end else begin
      glob_r <= (gclear ? 3'h0 : glob_r) | {DRV_ERR_EVT, RESET_EVT};
    end
  end

  // status byte layout, bit 7 reads zero
  always_comb begin
    status_nxt = 8'h00;
    status_nxt[ST_STOP_L +: 2] = STOP_LEFT;
    status_nxt[ST_VEL +: 2] = VEL_REACHED;
    status_nxt[ST_ERR +: 2] = glob_r[2:1];
    status_nxt[ST_RST] = glob_r[0];
  end

  // status latched at end of each access
  always_ff @(posedge CLK) begin
    if (RST) begin
      status_r <= STATUS_RST;
    end else if (state_r == S_ISSUE) begin
      status_r <= status_nxt;
    end
  end

  // registered copies of flag and disable outputs
  always_ff @(posedge CLK) begin
    if (RST) begin
      GLOBAL_FLAGS <= GFLAGS_RST;
      DRIVER_DISABLE <= 1'b1;
    end else begin
      GLOBAL_FLAGS <= glob_r;
      DRIVER_DISABLE <= filt_r[IN_DIS];
    end
  end

  assign REG_WR = reg_wr_r;
  assign REG_RD = reg_rd_r;
  assign REG_ADDR = reg_addr_r;
  assign REG_WDATA = reg_wdata_r;

endmodule

//--- design/mcs_host_end.sv
// controller end of the serial link: a mode 3 master driven by
// software over an Avalon-MM slave with waitrequest
// assumes the device samples its pins on its own system clock
`timescale 1ns/1ps
module mcs_host_end
  import mcs_pkg::*;
#(
  parameter int HALF_DIV = HALF_DIV_DEF
) (
  // system
  input wire logic CLK,
  input wire logic RST,
  // serial link
  mcs_link_if.host LINK,
  // avalon-mm slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST
);

  typedef enum logic [5:0] {
    H_IDLE = 6'b000001,
    H_LEAD = 6'b000010,
    H_LOW = 6'b000100,
    H_HIGH = 6'b001000,
    H_TRAIL = 6'b010000,
    H_GAP = 6'b100000
  } mcs_hstate_e;

  mcs_hstate_e state_r;
  logic wait_r, acc, start;
  logic [31:0] rdata_bus_r, wdata_r, reply_r;
  logic [7:0] cmd_r, rstat_r;
  logic [7:0] div_r;
  logic div_end;
  logic [CNT_W-1:0] bit_r;
  logic [FRAME_BITS-1:0] tx_r, rx_r;
  logic sck_r, sel_n_r, mosi_r;
  logic m1_r, m2_r;

  // merge a bus write under its byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // every access waits exactly one cycle
  assign acc = (AVS_READ | AVS_WRITE) & ~wait_r;
  assign start = acc & AVS_WRITE & (AVS_ADDRESS == CMD_OFS) &
                 AVS_BYTEENABLE[0] & (state_r == H_IDLE);

  always_ff @(posedge CLK) begin
    if (RST) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= ~((AVS_READ | AVS_WRITE) & wait_r);
    end
  end

  // bus read data, unmapped offsets read zero
  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_bus_r <= '0;
    end else if (AVS_READ && wait_r) begin
      // captured a cycle early so data stands when waitrequest is low
      case (AVS_ADDRESS)
        CMD_OFS: rdata_bus_r <= {24'h0, cmd_r};
        WDATA_OFS: rdata_bus_r <= wdata_r;
        RDATA_OFS: rdata_bus_r <= reply_r;
        STAT_OFS: begin
          rdata_bus_r <= '0;
          rdata_bus_r[STAT_BYTE_LSB +: 8] <= rstat_r;
          rdata_bus_r[STAT_BUSY] <= (state_r != H_IDLE);
        end
        default: rdata_bus_r <= '0;
      endcase
    end
  end

  // command and data registers; a command while busy is dropped
  always_ff @(posedge CLK) begin
    if (RST) begin
      cmd_r <= '0;
      wdata_r <= '0;
    end else begin
      if (start) begin
        cmd_r <= AVS_WRITEDATA[7:0];
      end
      if (acc && AVS_WRITE && AVS_ADDRESS == WDATA_OFS) begin
        wdata_r <= be_merge(wdata_r, AVS_WRITEDATA, AVS_BYTEENABLE);
      end
    end
  end

  assign div_end = (div_r == 8'(HALF_DIV - 1));

  // each half period lasts HALF_DIV system clocks
  always_ff @(posedge CLK) begin
    if (RST || state_r == H_IDLE || div_end) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // miso synchroniser, only m2_r reads m1_r
  always_ff @(posedge CLK) begin
    if (RST) begin
      m1_r <= 1'b0;
      m2_r <= 1'b0;
    end else begin
      m1_r <= LINK.miso;
      m2_r <= m1_r;
    end
  end

  // frame sequencer
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_r <= H_IDLE;
      sck_r <= 1'b1;
      sel_n_r <= 1'b1;
      mosi_r <= 1'b0;
      tx_r <= '0;
      rx_r <= '0;
      bit_r <= '0;
      reply_r <= '0;
      rstat_r <= '0;
    end else begin
      case (state_r)
        H_IDLE: begin
          if (start) begin
            // bit 7 of the command is the write flag
            // address byte then 32 data bits
            tx_r <= {AVS_WRITEDATA[7:0], wdata_r};
            mosi_r <= AVS_WRITEDATA[7];
            // select falls while clock idles high
            sel_n_r <= 1'b0;
            bit_r <= '0;
            state_r <= H_LEAD;
          end
        end
        H_LEAD: begin
          if (div_end) begin
            sck_r <= 1'b0;
            state_r <= H_LOW;
          end
        end
        H_LOW: begin
          // take the bit the device drove after the previous fall
          // its pin latency is about six clocks plus our two-flop sync
          if (div_r == 8'h00 && bit_r != 6'h00) begin
            rx_r <= {rx_r[FRAME_BITS-2:0], m2_r};
          end
          if (div_end) begin
            sck_r <= 1'b1;
            state_r <= H_HIGH;
          end
        end
        H_HIGH: begin
          // clock stays high between frames, falls between bits
          if (div_end) begin
            bit_r <= bit_r + 6'h01;
            if (bit_r == FRAME_CNT - 6'h01) begin
              state_r <= H_TRAIL;
            end else begin
              sck_r <= 1'b0;
              tx_r <= {tx_r[FRAME_BITS-2:0], 1'b0};
              mosi_r <= tx_r[FRAME_BITS-2];
              state_r <= H_LOW;
            end
          end
        end
        H_TRAIL: begin
          // exactly 40 clocks given, select rises with clock high
          if (div_r == 8'h00) begin
            rx_r <= {rx_r[FRAME_BITS-2:0], m2_r};
          end
          if (div_end) begin
            sel_n_r <= 1'b1;
            rstat_r <= rx_r[FRAME_BITS-1:DATA_W];
            reply_r <= rx_r[DATA_W-1:0];
            state_r <= H_GAP;
          end
        end
        H_GAP: begin
          // select high time lets the device commit the frame
          if (div_end) begin
            state_r <= H_IDLE;
          end
        end
        default: begin
          state_r <= H_IDLE;
        end
      endcase
    end
  end

  assign LINK.sck = sck_r;
  assign LINK.select_low_line_n = sel_n_r;
  assign LINK.mosi = mosi_r;
  assign AVS_READDATA = rdata_bus_r;
  assign AVS_WAITREQUEST = wait_r;

endmodule

//--- verif/mcs_link_props.sv
// checker for the wires of the serial link between host and device
// assumes one system clock and a synchronous active high reset
`timescale 1ns/1ps
module mcs_link_props
  import mcs_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // link wires
  input wire logic sck,
  input wire logic select_low_line_n,
  input wire logic mosi,
  input wire logic miso
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  logic [CNT_W-1:0] rise_cnt_r;

  // rises counted per frame, cleared while deselected
  always_ff @(posedge CLK) begin
    if (RST || select_low_line_n) begin
      rise_cnt_r <= 6'h00;
    end else if ($rose(sck)) begin
      rise_cnt_r <= rise_cnt_r + 6'h01;
    end
  end

  a_sck_idle_high: assert property (select_low_line_n |-> sck)
    else $error("sck low while deselected");
  a_open_sck_high: assert property (
    $fell(select_low_line_n) |-> sck [*3])
    else $error("sck not high at frame start");
  a_low_half_width: assert property (
    $fell(sck) |-> !sck [*4] ##1 sck)
    else $error("sck low half not four cycles");
  a_high_half_width: assert property ($rose(sck) |-> sck [*4])
    else $error("sck high half too short");
  a_mosi_steady_high: assert property (
    (!select_low_line_n && !$past(select_low_line_n) && sck
      && $past(sck)) |-> $stable(mosi))
    else $error("mosi moved while sck high");
  a_forty_rises: assert property (
    $rose(select_low_line_n) |-> rise_cnt_r == FRAME_CNT)
    else $error("frame without forty clocks");
  a_close_sck_high: assert property (
    $rose(select_low_line_n) |-> sck && $past(sck))
    else $error("select rose with sck low");
  a_select_gap: assert property (
    $rose(select_low_line_n) |-> select_low_line_n [*6])
    else $error("select high time too short");
  a_frame_bound: assert property (
    $fell(select_low_line_n) |-> ##[300:400] $rose(select_low_line_n))
    else $error("frame length out of range");

  // main scenarios reached
  c_frame_done: cover property ($rose(select_low_line_n));
  c_miso_high: cover property (!select_low_line_n && miso);
  c_next_frame: cover property (
    $rose(select_low_line_n) ##[6:80] $fell(select_low_line_n));
endmodule

//--- verif/motion_ctrl_spi_slave_port_tb_top.sv
// bench joining host end and device end; a second device is bit-banged
// assumes 20 MHz clock, host driven over avalon-mm by the tasks below
`timescale 1ns/1ps
module motion_ctrl_spi_slave_port_tb_top
  import mcs_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] av_addr = 4'h0;
  logic av_rd_s = 1'b0;
  logic av_wr_s = 1'b0;
  logic [31:0] av_wd = 32'h0;
  logic [31:0] av_rdata;
  logic av_wait;
  logic reg_wr, reg_rd, wr2, rd2, dis_out;
  logic [6:0] reg_addr, addr2, a2;
  logic [31:0] reg_wdata, wd2, d2;
  logic [1:0] stop_l = 2'h1;
  logic [1:0] vel = 2'h2;
  logic [1:0] drv_err = 2'h0;
  logic rst_evt = 1'b0;
  logic dis_in = 1'b1;
  logic [2:0] gflags;
  logic [31:0] regs [128];
  int n2 = 0;
  int n_rd = 0;
  int n_wr = 0;
  int num_errors = 0;
  int comparisons = 0;
  logic [39:0] cmd_t [6] = '{40'h10deadbeef, 40'ha2a5c30f01,
    40'h1000000000, 40'h0100000000, 40'h2200000000, 40'ha200000000};
  logic [31:0] er_t [6] = '{32'h0, 32'h80001234, 32'ha5c30f01,
    32'h80001234, 32'h7, 32'ha5c30f01};
  logic [7:0] es_t [6] = '{8'h01, 8'h31, 8'h31, 8'h35, 8'h35, 8'h30};

  mcs_link_if lk();
  mcs_link_if lk2();

  always #25 clk = ~clk;

  mcs_host_end u_mcs_host_end (.CLK(clk), .RST(rst), .LINK(lk.host),
    .AVS_ADDRESS(av_addr), .AVS_READ(av_rd_s), .AVS_WRITE(av_wr_s),
    .AVS_WRITEDATA(av_wd), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(av_rdata), .AVS_WAITREQUEST(av_wait));
  mcs_dev_end u_mcs_dev_end (.CLK(clk), .RST(rst), .LINK(lk.dev),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_RDATA(regs[reg_addr]),
    .STOP_LEFT(stop_l), .VEL_REACHED(vel), .DRV_ERR_EVT(drv_err),
    .RESET_EVT(rst_evt), .GLOBAL_FLAGS(gflags),
    .DRIVER_DISABLE_IN(dis_in), .DRIVER_DISABLE(dis_out));
  // second device faces the bench, which breaks framing on purpose
  mcs_dev_end u_mcs_dev_end2 (.CLK(clk), .RST(rst), .LINK(lk2.dev),
    .REG_WR(wr2), .REG_RD(rd2), .REG_ADDR(addr2), .REG_WDATA(wd2),
    .REG_RDATA(32'h0), .STOP_LEFT(stop_l), .VEL_REACHED(vel),
    .DRV_ERR_EVT(drv_err), .RESET_EVT(rst_evt), .GLOBAL_FLAGS(),
    .DRIVER_DISABLE_IN(dis_in), .DRIVER_DISABLE());
  mcs_link_props u_mcs_link_props (.CLK(clk), .RST(rst), .sck(lk.sck),
    .select_low_line_n(lk.select_low_line_n), .mosi(lk.mosi),
    .miso(lk.miso));

  // register file behind device one, written on its strobe
  always @(posedge clk) begin
    if (reg_wr) regs[reg_addr] <= reg_wdata;
    if (reg_wr) n_wr <= n_wr + 1;
    if (reg_rd) n_rd <= n_rd + 1;
  end

  // strobes of device two, counted to see which frames commit
  always @(posedge clk) begin
    if (wr2 || rd2) begin
      n2 <= n2 + 1;
      a2 <= addr2;
      d2 <= wd2;
    end
  end

  task complete_run;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // request held until waitrequest is seen low at an edge
  task av_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    av_addr <= a;
    av_wd <= d;
    av_wr_s <= 1'b1;
    @(posedge clk);
    while (av_wait !== 1'b0) @(posedge clk);
    av_wr_s <= 1'b0;
  endtask

  task av_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    av_addr <= a;
    av_rd_s <= 1'b1;
    @(posedge clk);
    while (av_wait !== 1'b0) @(posedge clk);
    d = av_rdata;
    av_rd_s <= 1'b0;
  endtask

  // one whole frame through the host, waiting for busy to drop
  task frame(input logic [39:0] c, output logic [31:0] rep,
             output logic [7:0] st);
    logic [31:0] s;
    int k;
    av_wr(WDATA_OFS, c[31:0]);
    av_wr(CMD_OFS, {24'h0, c[39:32]});
    k = 0;
    s = 32'h1;
    while (s[STAT_BUSY] !== 1'b0 && k < 500) begin
      av_rd(STAT_OFS, s);
      k++;
    end
    if (k >= 500) num_errors++;
    av_rd(RDATA_OFS, rep);
    st = s[STAT_BYTE_LSB +: 8];
  endtask

  // mode 3 master by hand on link two, n clocks, miso read late
  task bb(input int n, input logic [47:0] b, output logic [47:0] q);
    q = 48'h0;
    @(posedge clk) lk2.select_low_line_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      lk2.sck <= 1'b0;
      lk2.mosi <= b[n-1-i];
      repeat (4) @(posedge clk);
      lk2.sck <= 1'b1;
      repeat (4) @(posedge clk);
      q = {q[46:0], lk2.miso};
    end
    repeat (4) @(posedge clk);
    lk2.select_low_line_n <= 1'b1;
    lk2.mosi <= ~lk2.mosi;
    repeat (10) @(posedge clk);
  endtask

  initial begin
    #1000000;
    num_errors++;
    complete_run();
  end

  initial begin
    logic [31:0] rep;
    logic [7:0] st;
    logic [47:0] q;
    lk2.sck = 1'b1;
    lk2.select_low_line_n = 1'b1;
    lk2.mosi = 1'b0;
    for (int i = 0; i < 128; i++) regs[i] = 32'h0;
    regs[7'h10] = 32'h80001234;
    regs[7'h01] = 32'h7;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    // a one-cycle dip is a glitch, a held level passes
    @(posedge clk) dis_in <= 1'b0;
    @(posedge clk) dis_in <= 1'b1;
    repeat (6) @(posedge clk);
    chk("glitch", 32'h1, {31'h0, dis_out});
    dis_in <= 1'b0;
    repeat (8) @(posedge clk);
    chk("disable", 32'h0, {31'h0, dis_out});
    av_rd(4'h2, rep);
    chk("unmapped", 32'h0, rep);
    for (int i = 0; i < 6; i++) begin
      frame(cmd_t[i], rep, st);
      chk("reply", er_t[i], rep);
      chk("status", {24'h0, es_t[i]}, {24'h0, st});
      if (i == 1) begin
        @(posedge clk) drv_err <= 2'h2;
        @(posedge clk) drv_err <= 2'h0;
        repeat (3) @(posedge clk);
        chk("flags set", 32'h5, {29'h0, gflags});
      end
      if (i == 3) chk("flags clear", 32'h0, {29'h0, gflags});
    end
    chk("read kept", 32'h80001234, regs[7'h10]);
    chk("write done", 32'h0, regs[7'h22]);
    chk("read strobes", 32'h4, 32'(n_rd));
    chk("write strobes", 32'h2, 32'(n_wr));
    bb(48, {8'h96, 40'hb30badcafe}, q);
    chk("chain out", 32'h96, {24'h0, q[7:0]});
    chk("chain status", 32'h01, {24'h0, q[47:40]});
    chk("chain data", 32'h0, q[39:8]);
    chk("commit count", 32'h1, 32'(n2));
    chk("commit addr", 32'h33, {25'h0, a2});
    chk("commit data", 32'h0badcafe, d2);
    bb(39, 48'h0, q);
    chk("short frame", 32'h1, 32'(n2));
    complete_run();
  end
endmodule
